// ### bench/gfs_remote_model.sv
`timescale 1ns/100ps
// ==========================================================
// Remote side: serializer GPIOs, link status, frame clocks
// ==========================================================
module gfs_remote_model (
  // Clock and control from the bench
  input wire logic clk,
  input wire logic step,
  input wire logic [31:0] word,
  input wire logic [1:0] fclk_run,
  // Remote levels
  output logic [3:0] port0_remote_gpio,
  output logic [3:0] port1_remote_gpio,
  output logic [1:0] port_lock,
  output logic [1:0] port_pass,
  output logic [1:0] port_enabled,
  output logic [3:0] ext_gpio,
  output logic [1:0] port_frame_clk
);
  logic div_q = 1'b0;

  initial begin
    {port0_remote_gpio, port1_remote_gpio, ext_gpio} = 12'h000;
    {port_lock, port_pass, port_enabled, port_frame_clk} = 8'h00;
  end

  // Levels move only on request, so that a check sees them settled.
  always @(posedge clk) begin
    if (step) begin
      {port0_remote_gpio, port1_remote_gpio, ext_gpio} <= word[11:0];
      {port_lock, port_pass, port_enabled} <= word[17:12];
    end
  end

  // A stopped frame clock rests low instead of keeping its last level.
  always @(posedge clk) begin
    div_q <= ~div_q;
    if (div_q) begin
      port_frame_clk <= (port_frame_clk ^ fclk_run) & fclk_run;
    end
  end
endmodule

// ### bench/tb_gpio3_output_mux_frame_sync_a_ctl.sv
`timescale 1ns/100ps
module tb_gpio3_output_mux_frame_sync_a_ctl;
  typedef struct {
    logic [2:0] kind;
    logic [15:0] exp;
  } gfs_note_s;
  localparam logic [2:0] K_PIN = 3'h0;
  localparam logic [2:0] K_OE = 3'h1;
  localparam logic [2:0] K_RD = 3'h2;
  localparam logic [2:0] K_CNT = 3'h3;
  localparam logic [2:0] K_HI = 3'h4;
  localparam logic [2:0] K_LO = 3'h5;
  localparam logic [2:0] K_FS = 3'h6;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic ref_tick = 1'b1;
  logic step = 1'b0;
  logic [31:0] word = 32'h0;
  logic [1:0] fclk_run = 2'h0;
  logic obs_v = 1'b0;
  logic clr = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] port0_remote_gpio, port1_remote_gpio, ext_gpio;
  logic [1:0] port_lock, port_pass, port_enabled, port_frame_clk;
  logic pin3_out, pin3_oe_n, frame_sync_a;
  logic fs_prev = 1'b0;
  logic [7:0] run_q = 8'h00;
  logic [7:0] rise_cnt = 8'h00;
  logic [7:0] fall_cnt = 8'h00;
  logic [7:0] hi_len = 8'h00;
  logic [7:0] lo_len = 8'h00;
  logic [7:0] ctl;
  logic [31:0] r;
  logic [15:0] got;
  gfs_note_s n;
  gfs_note_s notes[$];
  integer seed = 86095;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] ofs [7] = '{8'h13, 8'h14, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c};
  logic [15:0] prog [4] = '{16'h1900, 16'h1a03, 16'h1b00, 16'h1c01};
  logic [2:0] srcs [6] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h5, 3'h7};

  gfs_pin3_fsync gfs_pin3_fsync_i (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .port0_remote_gpio(port0_remote_gpio),
    .port1_remote_gpio(port1_remote_gpio),
    .port_lock(port_lock), .port_pass(port_pass),
    .port_enabled(port_enabled), .port_frame_clk(port_frame_clk),
    .ref_tick(ref_tick), .ext_gpio(ext_gpio), .pin3_out(pin3_out),
    .pin3_oe_n(pin3_oe_n), .frame_sync_a(frame_sync_a)
  );

  gfs_remote_model gfs_remote_model_i (
    .clk(clk), .step(step), .word(word), .fclk_run(fclk_run),
    .port0_remote_gpio(port0_remote_gpio),
    .port1_remote_gpio(port1_remote_gpio),
    .port_lock(port_lock), .port_pass(port_pass),
    .port_enabled(port_enabled), .ext_gpio(ext_gpio),
    .port_frame_clk(port_frame_clk)
  );

  // ==========================================================
  // Clock, timeout and closing report
  // ==========================================================
  initial begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Monitor: frame-sync edge statistics and note comparison
  // ==========================================================
  always @(posedge clk) begin
    fs_prev <= frame_sync_a;
    run_q <= (frame_sync_a === fs_prev) ? run_q + 8'h01 : 8'h01;
    if (frame_sync_a === 1'b1 && fs_prev === 1'b0) begin
      rise_cnt <= rise_cnt + 8'h01;
      lo_len <= run_q;
    end
    if (frame_sync_a === 1'b0 && fs_prev === 1'b1) begin
      fall_cnt <= fall_cnt + 8'h01;
      hi_len <= run_q;
    end
    if (clr) begin
      rise_cnt <= 8'h00;
      fall_cnt <= 8'h00;
    end
    if (obs_v) begin
      n = notes.pop_front();
      case (n.kind)
        K_PIN: got = {15'h0, pin3_out};
        K_OE: got = {15'h0, pin3_oe_n};
        K_RD: got = {8'h00, reg_rdata};
        K_CNT: got = {rise_cnt, fall_cnt};
        K_HI: got = {8'h00, hi_len};
        K_LO: got = {8'h00, lo_len};
        default: got = {15'h0, frame_sync_a};
      endcase
      compares++;
      if (got !== n.exp) begin
        bad_count++;
        $display("Error at %0t: expected %h, got %h", $time, n.exp, got);
      end
    end
  end

  // ==========================================================
  // Driver tasks and expectation model
  // ==========================================================
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic expect_now(input logic [2:0] k, input logic [15:0] e);
    notes.push_back('{k, e});
    obs_v <= 1'b1;
    @(posedge clk);
    obs_v <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    @(posedge clk);
    expect_now(K_RD, {8'h00, e});
  endtask

  task automatic clear_counts();
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask

  task automatic wait_n(input int c);
    repeat (c) @(posedge clk);
  endtask

  function automatic logic pin_exp(input logic [7:0] c);
    logic [3:0] g;
    logic p;
    p = c[2];
    g = p ? port1_remote_gpio : port0_remote_gpio;
    if (c[4:3] == 2'h0) begin
      if (!c[7]) return g[c[6:5]];
      if (c[7:5] == 3'h4) return port_lock[p];
      if (c[7:5] == 3'h5) return port_pass[p];
      return 1'b0;
    end
    if (c[4:2] != 3'h4) return 1'b0;
    case (c[7:5])
      3'h0: return c[1];
      3'h1: return |(port_lock & port_enabled);
      3'h2: return &(port_lock | ~port_enabled);
      3'h3: return &(port_pass | ~port_enabled);
      3'h4: return ext_gpio[0];
      default: return 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    wait_n(6);
    srst <= 1'b0;
    @(posedge clk);
    expect_now(K_OE, 16'h0001);
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    wr(8'h14, 8'hff);
    rd(8'h14, 8'h00);
    rd(8'hff, 8'h00);
    foreach (prog[i]) wr(prog[i][15:8], prog[i][7:0]);
    wr(gfs_pkg::FRAME_SYNC_CONTROL_OFS, 8'h40);
    clear_counts();
    wr(gfs_pkg::FRAME_SYNC_CONTROL_OFS, 8'h48);
    wr(gfs_pkg::FRAME_SYNC_CONTROL_OFS, 8'h48);
    rd(gfs_pkg::FRAME_SYNC_CONTROL_OFS, 8'h40);
    wait_n(12);
    expect_now(K_CNT, 16'h0101);
    expect_now(K_HI, 16'h0004);
    wr(gfs_pkg::FRAME_SYNC_CONTROL_OFS, 8'h78);
    wait_n(10);
    expect_now(K_CNT, 16'h0202);
    wr(gfs_pkg::FRAME_SYNC_CONTROL_OFS, 8'h44);
    wait_n(4);
    clear_counts();
    wr(gfs_pkg::FRAME_SYNC_CONTROL_OFS, 8'h4c);
    wait_n(10);
    expect_now(K_CNT, 16'h0101);
    expect_now(K_LO, 16'h0002);
    expect_now(K_FS, 16'h0001);
    wr(gfs_pkg::FRAME_SYNC_CONTROL_OFS, 8'h41);
    wait_n(30);
    expect_now(K_HI, 16'h0004);
    expect_now(K_LO, 16'h0002);
    wr(8'h1a, 8'h00);
    wait_n(10);
    expect_now(K_HI, 16'h0001);
    wr(8'h1c, 8'h02);
    wr(gfs_pkg::FRAME_SYNC_CONTROL_OFS, 8'h53);
    wait_n(30);
    expect_now(K_HI, 16'h0003);
    expect_now(K_LO, 16'h0003);
    wr(gfs_pkg::FRAME_SYNC_CONTROL_OFS, 8'h40);
    wait_n(6);
    clear_counts();
    wait_n(20);
    expect_now(K_CNT, 16'h0000);
    wr(8'h1a, 8'h03);
    for (int p = 0; p < 2; p++) begin
      wr(gfs_pkg::FRAME_SYNC_CONTROL_OFS, {3'h0, 1'(p), 4'h1});
      fclk_run <= 2'(2 - p);
      wait_n(4);
      clear_counts();
      wait_n(40);
      expect_now(K_CNT, 16'h0000);
      fclk_run <= 2'(p + 1);
      wait_n(80);
      expect_now(K_HI, 16'h0010);
      expect_now(K_LO, 16'h000c);
    end
    fclk_run <= 2'h0;
    wr(gfs_pkg::FRAME_SYNC_CONTROL_OFS, 8'h80);
    for (int s = 0; s < 6; s++) begin
      for (int k = 0; k < 8; k++) begin
        r = $random(seed);
        ctl = {3'(k), srcs[s], r[31:30]};
        word <= r;
        step <= 1'b1;
        wr(gfs_pkg::PIN3_CTL_OFS, ctl);
        step <= 1'b0;
        wait_n(6);
        if (ctl[0]) begin
          expect_now(K_PIN, {15'h0, pin_exp(ctl)});
        end
        expect_now(K_OE, {15'h0, ~ctl[0]});
        rd(gfs_pkg::PIN3_CTL_OFS, ctl);
      end
    end
    for (int k = 0; k < 8; k++) begin
      wr(gfs_pkg::FRAME_SYNC_CONTROL_OFS, {2'h2, 2'(k), 4'h0});
      word <= $random(seed);
      step <= 1'b1;
      @(posedge clk);
      step <= 1'b0;
      wait_n(6);
      expect_now(K_FS, {15'h0, ext_gpio[k % 4]});
    end
    report_and_stop();
  end
endmodule

// ### logic/gfs_phase_timer.sv
`timescale 1ns/100ps
module gfs_phase_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic start,
  input wire logic tick,
  input wire logic [gfs_pkg::PERIOD_W-1:0] period,
  // Status
  output logic busy,
  output logic expire
);

  logic [gfs_pkg::PERIOD_W-1:0] cnt_q;
  logic busy_q;

  // ==========================================================================
  // Phase counter
  // ==========================================================================
  // A loaded value N ends the phase on the (N+1)th timebase tick.
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q <= period;
      busy_q <= 1'b1;
    end else if (busy_q && tick) begin
      if (cnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign busy = busy_q;
  assign expire = busy_q && tick && (cnt_q == '0);

  zero_period_a: assert property (@(posedge clk) disable iff (srst)
    start && (period == '0) |=> busy && (cnt_q == '0))
    else $error("Zero period did not give a one-tick phase.");

endmodule

// ### logic/gfs_pin3_fsync.sv
`timescale 1ns/100ps
// Contract
// - Port source, select 000 drives remote GPIO0, 011 remote GPIO3.
// - Port source, 100 drives port lock, 101 port pass; rest reserved.
// - Status source, select 000 drives the local value bit.
// - Status source, 001 drives OR of enabled ports' lock.
// - Status source, 010 drives AND of enabled ports' lock.
// - Status source, 011 drives AND of enabled ports' pass.
// - Status source, 100 drives frame sync; rest reserved.
// - Source field bits 4:2: port 0, port 1, device status.
// - Bit 0 enables the pin output; bit 1 is the local level.
// - Frame-sync codes 0000/0001 use port 0/1 frame clock.
// - Frame-sync codes 01xx use the reference clock timebase.
// - Frame-sync codes 1000 to 1011 take external GPIO0 to GPIO3.
// - Writing one to bit 3 makes one frame-sync pulse from an internal source when idle and bit 0 is clear.
// - A started one-shot pulse runs its full length before another while its source stays internal.
// - The one-shot bit clears itself and always reads zero.
// - Bit 2 sets the initial frame-sync level.
// - Generation enable turns continuous frame-sync on or off.
// - Mode bit picks separate high/low counts or one 24-bit count.
// - A period value N gives a phase of N+1 timebase cycles.
module gfs_pin3_fsync (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  // Receive port status
  input wire logic [3:0] port0_remote_gpio,
  input wire logic [3:0] port1_remote_gpio,
  input wire logic [1:0] port_lock,
  input wire logic [1:0] port_pass,
  input wire logic [1:0] port_enabled,
  // Timebases and external pins
  input wire logic [1:0] port_frame_clk,
  input wire logic ref_tick,
  input wire logic [3:0] ext_gpio,
  // Pin and frame sync
  output logic pin3_out,
  output logic pin3_oe_n,
  output logic frame_sync_a
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0] pin3_ctl_q;
  logic [7:4] fs_src_q;
  logic fs_init_q;
  logic frame_sync_source_q;
  logic fs_gen_q;
  logic fs_shot_q;
  logic [7:0] fs_high1_q;
  logic [7:0] fs_high0_q;
  logic [7:0] fs_low1_q;
  logic [7:0] fs_low0_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      pin3_ctl_q <= gfs_pkg::PIN3_CTL_RST;
      fs_src_q <= gfs_pkg::FRAME_SYNC_CONTROL_RST[7:4];
      fs_init_q <= gfs_pkg::FRAME_SYNC_CONTROL_RST[gfs_pkg::FS_INIT_BIT];
      frame_sync_source_q <= gfs_pkg::FRAME_SYNC_CONTROL_RST[gfs_pkg::FRAME_SYNC_SOURCE_BIT];
      fs_gen_q <= gfs_pkg::FRAME_SYNC_CONTROL_RST[gfs_pkg::FS_GEN_BIT];
      fs_high1_q <= gfs_pkg::FS_TIME_RST;
      fs_high0_q <= gfs_pkg::FS_TIME_RST;
      fs_low1_q <= gfs_pkg::FS_TIME_RST;
      fs_low0_q <= gfs_pkg::FS_TIME_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        gfs_pkg::PIN3_CTL_OFS: pin3_ctl_q <= reg_wdata;
        gfs_pkg::FRAME_SYNC_CONTROL_OFS: begin
          fs_src_q <= reg_wdata[7:4];
          fs_init_q <= reg_wdata[gfs_pkg::FS_INIT_BIT];
          frame_sync_source_q <= reg_wdata[gfs_pkg::FRAME_SYNC_SOURCE_BIT];
          fs_gen_q <= reg_wdata[gfs_pkg::FS_GEN_BIT];
        end
        gfs_pkg::FS_HIGH1_OFS: fs_high1_q <= reg_wdata;
        gfs_pkg::FS_HIGH0_OFS: fs_high0_q <= reg_wdata;
        gfs_pkg::FS_LOW1_OFS: fs_low1_q <= reg_wdata;
        gfs_pkg::FS_LOW0_OFS: fs_low0_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // A one-shot request lives for one cycle and is never stored.
  always_ff @(posedge clk) begin
    if (srst) begin
      fs_shot_q <= 1'b0;
    end else begin
      fs_shot_q <= reg_wr && (reg_addr == gfs_pkg::FRAME_SYNC_CONTROL_OFS) &&
                   reg_wdata[gfs_pkg::FS_SHOT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        gfs_pkg::PIN3_CTL_OFS: reg_rdata <= pin3_ctl_q;
        gfs_pkg::FRAME_SYNC_CONTROL_OFS: begin
          reg_rdata <= {fs_src_q, 1'b0, fs_init_q, frame_sync_source_q,
                        fs_gen_q};
        end
        gfs_pkg::FS_HIGH1_OFS: reg_rdata <= fs_high1_q;
        gfs_pkg::FS_HIGH0_OFS: reg_rdata <= fs_high0_q;
        gfs_pkg::FS_LOW1_OFS: reg_rdata <= fs_low1_q;
        gfs_pkg::FS_LOW0_OFS: reg_rdata <= fs_low0_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  shot_reads_zero_a: assert property (@(posedge clk) disable iff (srst)
    reg_addr == gfs_pkg::FRAME_SYNC_CONTROL_OFS |=> !reg_rdata[gfs_pkg::FS_SHOT_BIT])
    else $error("One-shot bit read back as one.");

  // ==========================================================================
  // Pin input synchronisers
  // ==========================================================================
  logic [gfs_pkg::SYNC_W-1:0] meta_q;
  logic [gfs_pkg::SYNC_W-1:0] sync_q;
  logic [1:0] fclk_prev_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      sync_q <= '0;
      fclk_prev_q <= '0;
    end else begin
      meta_q <= {port_frame_clk, ext_gpio};
      sync_q <= meta_q;
      fclk_prev_q <= sync_q[5:4];
    end
  end

  logic [1:0] fclk_rise;
  assign fclk_rise = sync_q[5:4] & ~fclk_prev_q;

  // ==========================================================================
  // Frame-sync source decode
  // ==========================================================================
  logic fs_internal;
  logic fs_external;
  logic fs_tick;

  always_comb begin
    fs_tick = 1'b0;
    if (fs_src_q == gfs_pkg::FSRC_PORT0) begin
      fs_tick = fclk_rise[0];
    end else if (fs_src_q == gfs_pkg::FSRC_PORT1) begin
      fs_tick = fclk_rise[1];
    end else if (fs_src_q[7:6] == gfs_pkg::FSRC_REF_TOP) begin
      fs_tick = ref_tick;
    end
  end

  assign fs_internal = (fs_src_q == gfs_pkg::FSRC_PORT0) ||
                       (fs_src_q == gfs_pkg::FSRC_PORT1) ||
                       (fs_src_q[7:6] == gfs_pkg::FSRC_REF_TOP);
  assign fs_external = fs_src_q[7:6] == gfs_pkg::FSRC_EXT_TOP;

  // ==========================================================================
  // Frame-sync generator
  // ==========================================================================
  function automatic logic [gfs_pkg::PERIOD_W-1:0] phase_len(
    input logic level,
    input logic mode,
    input logic [7:0] hi1,
    input logic [7:0] hi0,
    input logic [7:0] lo1,
    input logic [7:0] lo0
  );
    if (mode) begin
      phase_len = {hi0, lo1, lo0};
    end else if (level) begin
      phase_len = {8'h00, hi1, hi0};
    end else begin
      phase_len = {8'h00, lo1, lo0};
    end
  endfunction

  gfs_pkg::gfs_state_e state_q;
  logic level_q;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_expire;
  logic next_level;

  always_comb begin
    tmr_start = 1'b0;
    next_level = level_q;
    case (state_q)
      gfs_pkg::FS_IDLE: begin
        next_level = fs_init_q;
        if (fs_internal && fs_gen_q) begin
          tmr_start = 1'b1;
          next_level = fs_init_q;
        end else if (fs_internal && fs_shot_q) begin
          tmr_start = 1'b1;
          next_level = ~fs_init_q;
        end
      end
      gfs_pkg::FS_RUN: begin
        if (fs_gen_q && fs_internal && tmr_expire) begin
          tmr_start = 1'b1;
          next_level = ~level_q;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= gfs_pkg::FS_IDLE;
      level_q <= 1'b0;
    end else begin
      case (state_q)
        gfs_pkg::FS_IDLE: begin
          level_q <= next_level;
          if (fs_internal && fs_gen_q) begin
            state_q <= gfs_pkg::FS_RUN;
          end else if (fs_internal && fs_shot_q) begin
            state_q <= gfs_pkg::FS_SHOT;
          end
        end
        gfs_pkg::FS_RUN: begin
          level_q <= next_level;
          if (!fs_gen_q || !fs_internal) begin
            state_q <= gfs_pkg::FS_IDLE;
            level_q <= fs_init_q;
          end
        end
        gfs_pkg::FS_SHOT: begin
          if (tmr_expire || !fs_internal) begin
            state_q <= gfs_pkg::FS_IDLE;
            level_q <= fs_init_q;
          end
        end
        default: state_q <= gfs_pkg::FS_IDLE;
      endcase
    end
  end

  gfs_phase_timer u_timer (
    .clk(clk),
    .srst(srst),
    .start(tmr_start),
    .tick(fs_tick),
    .period(phase_len(next_level, frame_sync_source_q, fs_high1_q, fs_high0_q,
                      fs_low1_q, fs_low0_q)),
    .busy(tmr_busy),
    .expire(tmr_expire)
  );

  logic fs_level;
  assign fs_level = fs_external ? sync_q[fs_src_q[5:4]] : level_q;

  shot_holds_a: assert property (@(posedge clk) disable iff (srst)
    state_q == gfs_pkg::FS_SHOT && fs_internal && !tmr_expire
      |=> state_q == gfs_pkg::FS_SHOT && tmr_busy)
    else $error("One-shot pulse ended before its period.");

  idle_level_a: assert property (@(posedge clk) disable iff (srst)
    state_q == gfs_pkg::FS_SHOT && tmr_expire |=> level_q == $past(fs_init_q))
    else $error("Frame sync did not return to its initial level.");

  // ==========================================================================
  // Pin multiplexer
  // ==========================================================================
  logic [2:0] pin_sel;
  logic [2:0] pin_src;
  logic [3:0] rgpio;
  logic pin_d;

  assign pin_sel = pin3_ctl_q[7:gfs_pkg::PIN3_SEL_LSB];
  assign pin_src = pin3_ctl_q[4:gfs_pkg::PIN3_SRC_LSB];
  assign rgpio = (pin_src == gfs_pkg::SRC_PORT1) ? port1_remote_gpio
                                                 : port0_remote_gpio;

  always_comb begin
    pin_d = 1'b0;
    if (pin_src == gfs_pkg::SRC_PORT0 || pin_src == gfs_pkg::SRC_PORT1) begin
      if (!pin_sel[2]) begin
        pin_d = rgpio[pin_sel[1:0]];
      end else if (pin_sel == gfs_pkg::SEL_LOCK) begin
        pin_d = port_lock[pin_src[0]];
      end else if (pin_sel == gfs_pkg::SEL_PASS) begin
        pin_d = port_pass[pin_src[0]];
      end
    end else if (pin_src == gfs_pkg::SRC_STATUS) begin
      case (pin_sel)
        gfs_pkg::SEL_LOCAL: begin
          pin_d = pin3_ctl_q[gfs_pkg::PIN3_VAL_BIT];
        end
        gfs_pkg::SEL_OR_LOCK: pin_d = |(port_lock & port_enabled);
        gfs_pkg::SEL_AND_LOCK: pin_d = &(port_lock | ~port_enabled);
        gfs_pkg::SEL_AND_PASS: pin_d = &(port_pass | ~port_enabled);
        gfs_pkg::SEL_FSYNC: pin_d = fs_level;
        default: pin_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin3_out <= 1'b0;
      pin3_oe_n <= 1'b1;
      frame_sync_a <= 1'b0;
    end else begin
      pin3_out <= pin_d;
      pin3_oe_n <= ~pin3_ctl_q[gfs_pkg::PIN3_EN_BIT];
      frame_sync_a <= fs_level;
    end
  end

  rx_gpio_a: assert property (@(posedge clk) disable iff (srst)
    pin_src == gfs_pkg::SRC_PORT1 && pin_sel == 3'h3
      |=> pin3_out == $past(port1_remote_gpio[3]))
    else $error("Pin does not carry remote GPIO3 of port 1.");

  rx_lock_a: assert property (@(posedge clk) disable iff (srst)
    pin_src == gfs_pkg::SRC_PORT0 && pin_sel == gfs_pkg::SEL_LOCK
      |=> pin3_out == $past(port_lock[0]))
    else $error("Pin does not carry port 0 lock.");

  local_val_a: assert property (@(posedge clk) disable iff (srst)
    pin_src == gfs_pkg::SRC_STATUS && pin_sel == gfs_pkg::SEL_LOCAL
      |=> pin3_out == $past(pin3_ctl_q[gfs_pkg::PIN3_VAL_BIT]))
    else $error("Pin does not carry the local value.");

  lock_or_a: assert property (@(posedge clk) disable iff (srst)
    pin_src == gfs_pkg::SRC_STATUS && pin_sel == gfs_pkg::SEL_OR_LOCK
      |=> pin3_out == ($past(port_lock[0] && port_enabled[0]) ||
                       $past(port_lock[1] && port_enabled[1])))
    else $error("Pin does not carry OR of enabled locks.");

  pass_and_a: assert property (@(posedge clk) disable iff (srst)
    pin_src == gfs_pkg::SRC_STATUS && pin_sel == gfs_pkg::SEL_AND_PASS &&
      port_enabled == 2'h3 |=> pin3_out == $past(port_pass[0] && port_pass[1]))
    else $error("Pin does not carry AND of enabled passes.");

  pin_fsync_a: assert property (@(posedge clk) disable iff (srst)
    pin_src == gfs_pkg::SRC_STATUS && pin_sel == gfs_pkg::SEL_FSYNC
      |=> pin3_out == frame_sync_a)
    else $error("Pin does not follow frame sync.");

  out_enable_a: assert property (@(posedge clk) disable iff (srst)
    reg_wr && reg_addr == gfs_pkg::PIN3_CTL_OFS && reg_wdata[0]
      |=> ##1 !pin3_oe_n)
    else $error("Pin output enable did not follow bit 0.");

endmodule

// ### logic/gfs_pkg.sv
package gfs_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] PIN3_CTL_OFS = 8'h13;
  localparam logic [7:0] RSVD_FIRST_OFS = 8'h14;
  localparam logic [7:0] RSVD_LAST_OFS = 8'h17;
  localparam logic [7:0] FRAME_SYNC_CONTROL_OFS = 8'h18;
  localparam logic [7:0] FS_HIGH1_OFS = 8'h19;
  localparam logic [7:0] FS_HIGH0_OFS = 8'h1a;
  localparam logic [7:0] FS_LOW1_OFS = 8'h1b;
  localparam logic [7:0] FS_LOW0_OFS = 8'h1c;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] PIN3_CTL_RST = 8'h00;
  localparam logic [7:0] FRAME_SYNC_CONTROL_RST = 8'h00;
  localparam logic [7:0] FS_TIME_RST = 8'h00;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int PIN3_SEL_LSB = 5;
  localparam int PIN3_SRC_LSB = 2;
  localparam int PIN3_VAL_BIT = 1;
  localparam int PIN3_EN_BIT = 0;
  localparam int FS_SRC_LSB = 4;
  localparam int FS_SHOT_BIT = 3;
  localparam int FS_INIT_BIT = 2;
  localparam int FRAME_SYNC_SOURCE_BIT = 1;
  localparam int FS_GEN_BIT = 0;

  // ==========================================================================
  // Codes
  // ==========================================================================
  localparam logic [2:0] SRC_PORT0 = 3'h0;
  localparam logic [2:0] SRC_PORT1 = 3'h1;
  localparam logic [2:0] SRC_STATUS = 3'h4;
  localparam logic [2:0] SEL_LOCK = 3'h4;
  localparam logic [2:0] SEL_PASS = 3'h5;
  localparam logic [2:0] SEL_LOCAL = 3'h0;
  localparam logic [2:0] SEL_OR_LOCK = 3'h1;
  localparam logic [2:0] SEL_AND_LOCK = 3'h2;
  localparam logic [2:0] SEL_AND_PASS = 3'h3;
  localparam logic [2:0] SEL_FSYNC = 3'h4;
  localparam logic [3:0] FSRC_PORT0 = 4'h0;
  localparam logic [3:0] FSRC_PORT1 = 4'h1;
  localparam logic [1:0] FSRC_REF_TOP = 2'h1;
  localparam logic [1:0] FSRC_EXT_TOP = 2'h2;

  localparam int SYNC_W = 6;
  localparam int PERIOD_W = 24;

  typedef enum logic [1:0] {
    FS_IDLE,
    FS_RUN,
    FS_SHOT
  } gfs_state_e;

endpackage
